// ---- src/sdag_regs.svh ----
// Constants for the segmented data address generator
`ifndef SDAG_REGS_SVH
`define SDAG_REGS_SVH

// SFR addresses of the segment registers
`define SDAG_SFR_SELECT    11'h0403
`define SDAG_SFR_DATA_SEG  11'h0441
`define SDAG_SFR_EXTRA_SEG 11'h0442
`define SDAG_SFR_BASE      11'h0400

// Reset values and fields
`define SDAG_SELECT_RST  8'h00
`define SDAG_SEG_RST     8'h00
`define SDAG_EWEN_BIT    7
`define SDAG_SP_IDX      3'h7
`define SDAG_SYS_SEG     8'h00

// Memory map
`define SDAG_INT_BITS    9
`define SDAG_RSV_NIBBLE  4'hF
`define SDAG_BIT_RAM_HI  3'h1
`define SDAG_BYTE_STEP   16'h0001
`define SDAG_WORD_STEP   16'h0002

`endif

// ---- src/sdag_pkg.sv ----
// Types for the segmented data address generator
package sdag_pkg;

   typedef enum logic [2:0] {
      SDAG_INDIRECT = 3'h0,
      SDAG_OFFSET   = 3'h1,
      SDAG_AUTOINC  = 3'h3,
      SDAG_DIRECT   = 3'h2,
      SDAG_BIT      = 3'h6
   } sdag_mode_t;

   typedef struct packed {
      logic        valid;
      sdag_mode_t  mode;
      logic [2:0]  ptr_idx;
      logic [15:0] ptr;
      logic [15:0] offset;
      logic        off_word;
      logic        word;
      logic        write;
      logic        force_ext;
      logic [10:0] direct;
      logic [9:0]  bit_addr;
   } sdag_req_t;

   typedef struct packed {
      logic        valid;
      logic [23:0] addr;
      logic        word;
      logic        write;
      logic        internal;
      logic        external;
      logic        sfr;
      logic        reserved;
      logic        blocked;
      logic [2:0]  bit_sel;
      logic        ptr_we;
      logic [15:0] ptr_next;
   } sdag_acc_t;

endpackage

// ---- src/sdag_top.sv ----
// Data address generator with segment registers and memory routing
`timescale 1ns/100ps
`include "sdag_regs.svh"

// What this block does
// - 256 segments of 64K, segment upper byte
// - Top 16 segments reserved, never stored
// - External memory starts above internal top
// - Internal memory 512 bytes from zero
// - Odd word address drops bit zero
// - Overlap range goes to internal memory
// - Forced external move goes external, except in reserved segments
// - Data space serves data only, no fetch
// - Address is segment byte above pointer
// - Per-pointer select bit, data or extra
// - Stack pointer: segment 0 system, data user
// - Extra write enable writable only in system
// - Signed 8/16-bit offset added to pointer
// - Alignment checked on final effective address
// - Post-increment by one byte, two word
// - Increment never changes segment register
// - Direct 10-bit address zero-extended, data segment
// - Direct 400h-7FFh decodes as SFR
// - Bit space over bytes 20h-3Fh
// - Privilege bit picks user or system mode

module sdag_top
   import sdag_pkg::*;
(
   input  wire logic        I_CLOCK,
   input  wire logic        I_RESETN,
   input  wire logic        I_PRIV,
   input  wire sdag_req_t   I_REQ,
   input  wire logic        I_SFR_WR,
   input  wire logic [10:0] I_SFR_ADDR,
   input  wire logic [7:0]  I_SFR_WDATA,
   output sdag_acc_t        O_ACC,
   output logic [7:0]       O_SFR_RDATA
);

   // ************************************
   // Segment registers
   // ************************************
   logic [7:0]  segment_select;
   logic [7:0]  data_segment;
   logic [7:0]  extra_segment;
   logic        user_extra_write_enable;
   logic        sys_mode;

   assign sys_mode = I_PRIV;
   assign user_extra_write_enable = segment_select[`SDAG_EWEN_BIT];

   wire         wr_select;
   wire         wr_data_seg;
   wire         wr_extra_seg;
   wire [7:0]   next_select;

   assign wr_select    = I_SFR_WR && (I_SFR_ADDR == `SDAG_SFR_SELECT);
   assign wr_data_seg  = I_SFR_WR && (I_SFR_ADDR == `SDAG_SFR_DATA_SEG);
   assign wr_extra_seg = I_SFR_WR && (I_SFR_ADDR == `SDAG_SFR_EXTRA_SEG);

   // Enable bit keeps its value on a user-mode write
   assign next_select = {sys_mode ? I_SFR_WDATA[7] : segment_select[7],
                         I_SFR_WDATA[6:0]};

   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         segment_select <= `SDAG_SELECT_RST;
         data_segment   <= `SDAG_SEG_RST;
         extra_segment  <= `SDAG_SEG_RST;
      end else begin
         if (wr_select) begin
            segment_select <= next_select;
         end
         if (wr_data_seg) begin
            data_segment <= I_SFR_WDATA;
         end
         if (wr_extra_seg) begin
            extra_segment <= I_SFR_WDATA;
         end
      end
   end

   wire [7:0]   next_rdata;

   assign next_rdata = (I_SFR_ADDR == `SDAG_SFR_SELECT)    ? segment_select :
                       (I_SFR_ADDR == `SDAG_SFR_DATA_SEG)  ? data_segment   :
                       (I_SFR_ADDR == `SDAG_SFR_EXTRA_SEG) ? extra_segment  :
                       8'h00;

   // ************************************
   // Pointer and segment selection
   // ************************************
   wire         is_sp;
   wire         ptr_mode;
   wire         use_extra;
   wire [7:0]   ptr_seg;
   wire [15:0]  off_ext;
   wire [15:0]  off_sum;
   wire [15:0]  eff_ptr;
   wire [15:0]  step;

   assign is_sp     = (I_REQ.ptr_idx == `SDAG_SP_IDX);
   assign ptr_mode  = (I_REQ.mode == SDAG_INDIRECT) ||
                      (I_REQ.mode == SDAG_OFFSET) ||
                      (I_REQ.mode == SDAG_AUTOINC);
   assign use_extra = !is_sp && segment_select[I_REQ.ptr_idx];
   assign ptr_seg   = is_sp ? (sys_mode ? `SDAG_SYS_SEG : data_segment) :
                      (use_extra ? extra_segment : data_segment);

   // Offset sign-extended, sum wraps in 16 bits
   assign off_ext = I_REQ.off_word ? I_REQ.offset :
                    {{8{I_REQ.offset[7]}}, I_REQ.offset[7:0]};
   assign off_sum = I_REQ.ptr + off_ext;
   assign eff_ptr = (I_REQ.mode == SDAG_OFFSET) ? off_sum : I_REQ.ptr;
   assign step    = I_REQ.word ? `SDAG_WORD_STEP : `SDAG_BYTE_STEP;

   // ************************************
   // Address forming
   // ************************************
   wire         dir_sfr;
   wire         bit_ram;
   wire         bit_sfr;
   wire [10:0]  bit_sfr_addr;
   wire [23:0]  raw_addr;
   wire         is_word;
   wire [23:0]  aligned;

   assign dir_sfr      = (I_REQ.mode == SDAG_DIRECT) && I_REQ.direct[10];
   assign bit_ram      = (I_REQ.mode == SDAG_BIT) &&
                         (I_REQ.bit_addr[9:8] == 2'b01);
   assign bit_sfr      = (I_REQ.mode == SDAG_BIT) && I_REQ.bit_addr[9];
   assign bit_sfr_addr = `SDAG_SFR_BASE | {5'h00, I_REQ.bit_addr[8:3]};

   // Segment byte on top of a 16-bit offset; no carry reaches it
   assign raw_addr =
      ptr_mode ? {ptr_seg, eff_ptr} :
      dir_sfr  ? {13'h0000, I_REQ.direct} :
      (I_REQ.mode == SDAG_DIRECT) ?
         {data_segment, 6'h00, I_REQ.direct[9:0]} :
      bit_sfr  ? {13'h0000, bit_sfr_addr} :
      {data_segment, 8'h00, `SDAG_BIT_RAM_HI, I_REQ.bit_addr[7:3]};

   // Bit accesses are byte wide; words drop bit zero after the offset
   assign is_word = I_REQ.word && (I_REQ.mode != SDAG_BIT);
   assign aligned = {raw_addr[23:1], raw_addr[0] & ~is_word};

   // ************************************
   // Routing and protection
   // ************************************
   wire         is_sfr;
   wire         is_mem;
   wire         is_rsv;
   wire         in_int;
   wire         blk;

   assign is_sfr = dir_sfr || bit_sfr;
   // Register-file bit addresses reach no memory
   assign is_mem = ptr_mode || (I_REQ.mode == SDAG_DIRECT && !dir_sfr) ||
                   bit_ram;
   assign is_rsv = is_mem && (aligned[23:20] == `SDAG_RSV_NIBBLE);
   assign in_int = (aligned[23:`SDAG_INT_BITS] == '0);
   assign blk    = I_REQ.write && !sys_mode && ptr_mode && use_extra &&
                   !user_extra_write_enable;

   sdag_acc_t   next_acc;

   always_comb begin
      next_acc          = '0;
      next_acc.valid    = I_REQ.valid;
      next_acc.addr     = aligned;
      next_acc.word     = is_word;
      next_acc.write    = I_REQ.write && !blk;
      next_acc.sfr      = is_sfr;
      next_acc.reserved = is_rsv;
      next_acc.blocked  = blk;
      next_acc.bit_sel  = (I_REQ.mode == SDAG_BIT) ? I_REQ.bit_addr[2:0] : 3'h0;
      // Overlap favours internal unless the move is forced out
      next_acc.internal = is_mem && !is_rsv && !I_REQ.force_ext &&
                          in_int;
      next_acc.external = is_mem && !is_rsv &&
                          (I_REQ.force_ext || !in_int);
      next_acc.ptr_we   = I_REQ.valid && (I_REQ.mode == SDAG_AUTOINC);
      next_acc.ptr_next = I_REQ.ptr + step;
      if (!I_REQ.valid) begin
         next_acc = '0;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_ACC       <= '0;
         O_SFR_RDATA <= 8'h00;
      end else begin
         O_ACC       <= next_acc;
         O_SFR_RDATA <= next_rdata;
      end
   end

   // ************************************
   // Assertions
   // ************************************
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_RESETN);

   a_word_even: assert property (
      O_ACC.valid && O_ACC.word && !O_ACC.sfr |-> !O_ACC.addr[0])
      else $error("word access at odd address");

   a_force_ext: assert property (
      I_REQ.valid && I_REQ.force_ext && ptr_mode
      |=> !O_ACC.internal)
      else $error("forced move reached internal memory");

   a_sp_system: assert property (
      I_REQ.valid && ptr_mode && is_sp && I_PRIV
      |=> O_ACC.addr[23:16] == 8'h00)
      else $error("system stack pointer not in segment 0");

   a_ewen_guard: assert property (
      wr_select && !I_PRIV
      |=> segment_select[7] == $past(segment_select[7]))
      else $error("enable bit changed in user mode");

   a_inc_word: assert property (
      I_REQ.valid && I_REQ.mode == SDAG_AUTOINC && I_REQ.word
      |=> O_ACC.ptr_we && O_ACC.ptr_next == 16'($past(I_REQ.ptr) + 16'h0002))
      else $error("word increment not two");

   a_inc_segment: assert property (
      I_REQ.valid && I_REQ.mode == SDAG_AUTOINC && !is_sp && !use_extra
      |=> O_ACC.addr[23:16] == $past(data_segment))
      else $error("segment moved during increment");

   a_direct_form: assert property (
      I_REQ.valid && I_REQ.mode == SDAG_DIRECT && !I_REQ.direct[10]
      |=> O_ACC.addr[23:1] == {$past(data_segment), 6'h00,
                               $past(I_REQ.direct[9:1])})
      else $error("direct address badly formed");

   a_sfr_decode: assert property (
      I_REQ.valid && dir_sfr
      |=> O_ACC.sfr && !O_ACC.internal && !O_ACC.external)
      else $error("SFR range reached memory");

   a_user_block: assert property (
      I_REQ.valid && blk |=> O_ACC.blocked && !O_ACC.write)
      else $error("user extra-segment write passed");

   a_reserved: assert property (
      O_ACC.reserved |-> !O_ACC.internal && !O_ACC.external)
      else $error("reserved segment routed to memory");

   c_autoinc: cover property (
      I_REQ.valid && I_REQ.mode == SDAG_AUTOINC ##1 O_ACC.ptr_we);
   c_blocked: cover property (O_ACC.blocked);
   c_forced: cover property (
      O_ACC.external && O_ACC.addr[23:`SDAG_INT_BITS] == '0);
   c_sfr_bit: cover property (O_ACC.sfr && O_ACC.bit_sel != 3'h0);

endmodule

// ---- test/sdag_mem_model.sv ----
// Counting stand-in for internal RAM and external data memory
`timescale 1ns/100ps
module sdag_mem_model
   import sdag_pkg::*;
(
   input  wire logic      i_clock,
   input  wire sdag_acc_t i_acc,
   output int             o_int_cnt,
   output int             o_ext_cnt
);
   int int_cnt = 0;
   int ext_cnt = 0;

   assign o_int_cnt = int_cnt;
   assign o_ext_cnt = ext_cnt;

   // Each answer stands one cycle, so one edge counts it once
   always @(posedge i_clock) begin
      if (i_acc.valid && i_acc.internal) int_cnt <= int_cnt + 1;
      if (i_acc.valid && i_acc.external) ext_cnt <= ext_cnt + 1;
   end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the data address generator
`timescale 1ns/100ps
`include "sdag_regs.svh"
module tb
   import sdag_pkg::*;
;
   logic        I_CLOCK = 0;
   logic        I_RESETN = 0;
   logic        I_PRIV = 1;
   sdag_req_t   I_REQ = '0;
   logic        I_SFR_WR = 0;
   logic [10:0] I_SFR_ADDR = '0;
   logic [7:0]  I_SFR_WDATA = '0;
   sdag_acc_t   O_ACC;
   logic [7:0]  O_SFR_RDATA;
   logic [7:0]  v;
   int          int_cnt;
   int          ext_cnt;
   int          errors = 0;
   int          compares = 0;

   always #10 I_CLOCK = ~I_CLOCK;

   sdag_top dut(.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN), .I_PRIV(I_PRIV), .I_REQ(I_REQ),
      .I_SFR_WR(I_SFR_WR), .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WDATA(I_SFR_WDATA),
      .O_ACC(O_ACC), .O_SFR_RDATA(O_SFR_RDATA));
   sdag_mem_model mem(.i_clock(I_CLOCK), .i_acc(O_ACC), .o_int_cnt(int_cnt), .o_ext_cnt(ext_cnt));

   // ************************
   // Shared tasks
   // ************************
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic sfr_wr(logic [10:0] a, logic [7:0] d);
      @(posedge I_CLOCK);
      I_SFR_WR <= 1;
      I_SFR_ADDR <= a;
      I_SFR_WDATA <= d;
      @(posedge I_CLOCK);
      I_SFR_WR <= 0;
   endtask

   task automatic sfr_rd(logic [10:0] a, output logic [7:0] d);
      @(posedge I_CLOCK);
      I_SFR_ADDR <= a;
      @(posedge I_CLOCK);
      #1 d = O_SFR_RDATA;
   endtask

   // Flags f are off_word, word, write, force_ext
   function automatic sdag_req_t mk(sdag_mode_t m, logic [2:0] i, logic [15:0] p, logic [15:0] o,
      logic [3:0] f);
      mk = '0;
      mk.valid = 1;
      mk.mode = m;
      mk.ptr_idx = i;
      mk.ptr = p;
      mk.offset = o;
      {mk.off_word, mk.word, mk.write, mk.force_ext} = f;
      mk.direct = p[10:0];
      mk.bit_addr = p[9:0];
   endfunction

   // Expected flags: valid, internal, external, sfr, reserved, blocked, write
   task automatic go(sdag_req_t r, logic [23:0] a, logic [6:0] fl);
      @(posedge I_CLOCK);
      I_REQ <= r;
      @(posedge I_CLOCK);
      I_REQ <= '0;
      #1;
      chk("addr", O_ACC.addr, a);
      chk("flags", {O_ACC.valid, O_ACC.internal, O_ACC.external, O_ACC.sfr, O_ACC.reserved,
         O_ACC.blocked, O_ACC.write}, fl);
   endtask

   // ************************
   // Test sequence
   // ************************
   initial begin
      repeat (6) @(posedge I_CLOCK);
      I_RESETN <= 1;
      sfr_rd(`SDAG_SFR_SELECT, v);
      chk("select", v, 8'h00);
      go(mk(SDAG_INDIRECT, 3'h0, 16'h0100, 16'h0000, 4'h0), 24'h00_0100, 7'h60);
      go(mk(SDAG_INDIRECT, 3'h0, 16'h0100, 16'h0000, 4'h1), 24'h00_0100, 7'h50);
      go(mk(SDAG_INDIRECT, 3'h0, 16'h0200, 16'h0000, 4'h0), 24'h00_0200, 7'h50);
      sfr_wr(`SDAG_SFR_DATA_SEG, 8'hF5);
      go(mk(SDAG_INDIRECT, 3'h0, 16'h0010, 16'h0000, 4'h1), 24'hF5_0010, 7'h44);
      $display("test routing done");
      sfr_wr(`SDAG_SFR_DATA_SEG, 8'h12);
      sfr_wr(`SDAG_SFR_EXTRA_SEG, 8'h34);
      sfr_wr(`SDAG_SFR_SELECT, 8'h04);
      sfr_rd(`SDAG_SFR_DATA_SEG, v);
      chk("data segment", v, 8'h12);
      sfr_rd(`SDAG_SFR_EXTRA_SEG, v);
      chk("extra segment", v, 8'h34);
      sfr_rd(`SDAG_SFR_BASE, v);
      chk("unmapped", v, 8'h00);
      go(mk(SDAG_INDIRECT, 3'h2, 16'h5000, 16'h0000, 4'h2), 24'h34_5000, 7'h51);
      @(posedge I_CLOCK);
      I_PRIV <= 0;
      sfr_wr(`SDAG_SFR_SELECT, 8'h84);
      sfr_rd(`SDAG_SFR_SELECT, v);
      chk("select", v, 8'h04);
      go(mk(SDAG_INDIRECT, 3'h2, 16'h5000, 16'h0000, 4'h2), 24'h34_5000, 7'h52);
      go(mk(SDAG_INDIRECT, 3'h0, 16'h5000, 16'h0000, 4'h2), 24'h12_5000, 7'h51);
      go(mk(SDAG_INDIRECT, 3'h7, 16'h0100, 16'h0000, 4'h0), 24'h12_0100, 7'h50);
      @(posedge I_CLOCK);
      I_PRIV <= 1;
      go(mk(SDAG_INDIRECT, 3'h7, 16'h0100, 16'h0000, 4'h0), 24'h00_0100, 7'h60);
      $display("test segments done");
      go(mk(SDAG_OFFSET, 3'h0, 16'h1001, 16'h0003, 4'hC), 24'h12_1004, 7'h50);
      chk("write back", O_ACC.ptr_we, 1'b0);
      go(mk(SDAG_OFFSET, 3'h0, 16'h1001, 16'h00FE, 4'h4), 24'h12_0FFE, 7'h50);
      chk("word", O_ACC.word, 1'b1);
      go(mk(SDAG_OFFSET, 3'h0, 16'hFFFF, 16'h0002, 4'h8), 24'h12_0001, 7'h50);
      go(mk(SDAG_AUTOINC, 3'h0, 16'hFFFF, 16'h0000, 4'h4), 24'h12_FFFE, 7'h50);
      chk("next", {O_ACC.ptr_we, O_ACC.ptr_next}, 17'h1_0001);
      go(mk(SDAG_AUTOINC, 3'h0, 16'h0010, 16'h0000, 4'h0), 24'h12_0010, 7'h50);
      chk("next", {O_ACC.ptr_we, O_ACC.ptr_next}, 17'h1_0011);
      $display("test pointer modes done");
      go(mk(SDAG_DIRECT, 3'h0, 16'h03FF, 16'h0000, 4'h0), 24'h12_03FF, 7'h50);
      go(mk(SDAG_DIRECT, 3'h0, 16'h0410, 16'h0000, 4'h0), 24'h00_0410, 7'h48);
      go(mk(SDAG_BIT, 3'h0, 16'h01AB, 16'h0000, 4'h0), 24'h12_0035, 7'h50);
      chk("bit", O_ACC.bit_sel, 3'h3);
      go(mk(SDAG_BIT, 3'h0, 16'h0213, 16'h0000, 4'h0), 24'h00_0402, 7'h48);
      chk("bit", O_ACC.bit_sel, 3'h3);
      @(posedge I_CLOCK);
      #1;
      chk("internal", int_cnt, 2);
      chk("external", ext_cnt, 13);
      $display("test direct and bit done");
      tally_and_finish;
   end

   initial begin
      repeat (2000) @(posedge I_CLOCK);
      errors++;
      tally_and_finish;
   end
endmodule
